/* hw/qrp_defs.svh */
/*
 Timing constants for the panel timing receiver.
 Assumes inclusion by bare name from the package and the top module.
*/
`ifndef QRP_DEFS_SVH
`define QRP_DEFS_SVH
`define QRP_VIS_PIXELS     9'd320
`define QRP_VIS_LINES      8'd240
`define QRP_FIXED_HSTART   9'd52
`define QRP_VSTART_LINE    9'd8
`define QRP_DOT_MAX_KHZ    7500
`define QRP_CLK_KHZ        10000
`define QRP_LINE_MAX       9'd440
`define QRP_FRAME_MAX      9'd284
`define QRP_X_LAST         9'd319
`define QRP_Y_LAST         8'd239
`endif

/* hw/qrp_panel_timing.sv */
/*
 Panel-side receiver of parallel RGB video: finds the dot clock edges,
 counts pixels and lines, places the visible 320x240 window and gives out
 addressed pixels, plus the backlight enable taken from the dimming pin.
 Assumes all pins are asynchronous to clk and the dot clock is slower
 than half of clk.
*/
`include "qrp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module qrp_panel_timing (
  input  wire logic              clk,                 // System clock, 10 MHz
  input  wire logic              rst,                 // Synchronous reset, high
  input  wire qrp_pkg::qrp_video_t video_in,          // Video pins from controller
  input  wire logic              scan_reverse_select, // Mirror select pin
  input  wire logic              dimming_in,          // Backlight dimming pin
  output logic                   backlight_on,        // Backlight drive
  output qrp_pkg::qrp_out_t      pixel_out,           // Addressed pixel out
  output logic                   frame_start          // Pulse at visible frame start
);
  import qrp_pkg::*;

  typedef enum logic [1:0] {QRP_IDLE, QRP_WAIT, QRP_ACTIVE} qrp_hstate_t;

  // Mirror a position about the last index
  function automatic logic [8:0] qrp_mirror(input logic [8:0] pos, input logic [8:0] last);
    qrp_mirror = last - pos;
  endfunction

  // Two-stage synchronisers for all pins
  localparam int PW = $bits(qrp_video_t) + 2;
  logic [PW-1:0] sync1_q, sync2_q, sync1_d, sync2_d;
  logic          dclk_prev_q, dclk_prev_d;

  always_comb begin
    sync1_d     = {video_in, scan_reverse_select, dimming_in};
    sync2_d     = sync1_q;
    dclk_prev_d = sync2_q[PW-1];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q     <= '0;
      sync2_q     <= '0;
      dclk_prev_q <= 1'b0;
    end else begin
      sync1_q     <= sync1_d;
      sync2_q     <= sync2_d;
      dclk_prev_q <= dclk_prev_d;
    end
  end

  qrp_video_t vid;
  logic       rev_sel;
  logic       dim_s;
  logic       dot_edge;
  assign vid      = sync2_q[PW-1:2];
  assign rev_sel  = sync2_q[1];
  assign dim_s    = sync2_q[0];
  // Rising dot clock edge seen in the clk domain
  assign dot_edge = vid.pixel_dot_clock & ~dclk_prev_q;

  // Timing counters and placement state
  logic [8:0]  hcnt_q, hcnt_d;      // Dots since line sync fall
  logic [8:0]  lcnt_q, lcnt_d;      // Lines since frame sync fall
  logic [8:0]  xcnt_q, xcnt_d;      // Visible pixel index
  logic [7:0]  ycnt_q, ycnt_d;      // Visible line index
  logic        hs_prev_q, hs_prev_d;
  logic        vs_prev_q, vs_prev_d;
  logic        en_prev_q, en_prev_d;
  logic        en_seen_q, en_seen_d; // Window enable used this line
  qrp_hstate_t hst_q, hst_d;
  qrp_out_t    out_q, out_d;
  logic        fs_q, fs_d;

  logic hs_fall, vs_fall, en_rise, vline;

  always_comb begin
    hs_fall   = hs_prev_q & ~vid.line_sync_n;
    vs_fall   = vs_prev_q & ~vid.frame_sync_n;
    en_rise   = ~en_prev_q & vid.line_window_valid;
    hcnt_d    = hcnt_q;
    lcnt_d    = lcnt_q;
    xcnt_d    = xcnt_q;
    ycnt_d    = ycnt_q;
    hs_prev_d = hs_prev_q;
    vs_prev_d = vs_prev_q;
    en_prev_d = en_prev_q;
    en_seen_d = en_seen_q;
    hst_d     = hst_q;
    out_d     = out_q;
    out_d.valid = 1'b0;
    fs_d      = 1'b0;
    // visible lines start at line 8
    vline = (lcnt_q >= `QRP_VSTART_LINE) &&
            (lcnt_q < `QRP_VSTART_LINE + {1'b0, `QRP_VIS_LINES});
    if (dot_edge) begin
      hs_prev_d = vid.line_sync_n;
      vs_prev_d = vid.frame_sync_n;
      en_prev_d = vid.line_window_valid;
      if (hcnt_q != `QRP_LINE_MAX)
        hcnt_d = hcnt_q + 9'd1;
      if (hs_fall) begin
        hcnt_d    = 9'd1;
        en_seen_d = 1'b0;
        hst_d     = QRP_WAIT;
        if (lcnt_q != `QRP_FRAME_MAX)
          lcnt_d = lcnt_q + 9'd1;
        // Step the row at each line sync inside the visible band
        if (vline)
          ycnt_d = ycnt_q + 8'd1;
        if (lcnt_q == `QRP_VSTART_LINE - 9'd1) begin
          ycnt_d = 8'd0;
          fs_d   = 1'b1;
        end
      end
      if (vs_fall) begin
        lcnt_d = 9'd1;
        ycnt_d = 8'd0;
      end
      case (hst_q)
        QRP_WAIT: begin
          if (en_rise && !hs_fall) begin
            en_seen_d = 1'b1;
            hst_d     = vline ? QRP_ACTIVE : QRP_IDLE;
            xcnt_d    = 9'd0;
          end else if (!en_seen_q && !vid.line_window_valid &&
                       hcnt_q == `QRP_FIXED_HSTART - 9'd1 && !hs_fall) begin
            hst_d  = vline ? QRP_ACTIVE : QRP_IDLE;
            xcnt_d = 9'd0;
          end
        end
        QRP_ACTIVE: begin
          if (hs_fall) begin
            hst_d = QRP_WAIT;
          end else begin
            out_d.valid = 1'b1;
            out_d.pixel = vid.pixel;
            out_d.col = rev_sel ? qrp_mirror(xcnt_q, `QRP_X_LAST) : xcnt_q;
            out_d.row = 8'(rev_sel ? qrp_mirror({1'b0, ycnt_q}, {1'b0, `QRP_Y_LAST}) : {1'b0, ycnt_q});
            if (xcnt_q == `QRP_X_LAST)
              hst_d = QRP_IDLE;
            else
              xcnt_d = xcnt_q + 9'd1;
          end
        end
        QRP_IDLE: begin
        end
        default: begin
          hst_d = QRP_IDLE;
        end
      endcase
      // lines outside the visible band, 8 to 247, never become active
      if (!vline && hst_d == QRP_ACTIVE)
        hst_d = QRP_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hcnt_q    <= '0;
      lcnt_q    <= '0;
      xcnt_q    <= '0;
      ycnt_q    <= '0;
      hs_prev_q <= 1'b1;
      vs_prev_q <= 1'b1;
      en_prev_q <= 1'b0;
      en_seen_q <= 1'b0;
      hst_q     <= QRP_IDLE;
      out_q     <= '0;
      fs_q      <= 1'b0;
    end else begin
      hcnt_q    <= hcnt_d;
      lcnt_q    <= lcnt_d;
      xcnt_q    <= xcnt_d;
      ycnt_q    <= ycnt_d;
      hs_prev_q <= hs_prev_d;
      vs_prev_q <= vs_prev_d;
      en_prev_q <= en_prev_d;
      en_seen_q <= en_seen_d;
      hst_q     <= hst_d;
      out_q     <= out_d;
      fs_q      <= fs_d;
    end
  end

  // Backlight follows dimming input
  logic bl_q, bl_d;
  always_comb begin
    bl_d = dim_s;
  end

  always_ff @(posedge clk) begin
    if (rst)
      bl_q <= 1'b0;
    else
      bl_q <= bl_d;
  end

  assign backlight_on = bl_q;
  assign pixel_out    = out_q;
  assign frame_start  = fs_q;
endmodule
`default_nettype wire

/* hw/qrp_pkg.sv */
/*
 Types shared by the panel timing receiver.
 Assumes qrp_defs.svh is on the include path.
*/
`include "qrp_defs.svh"
package qrp_pkg;
  // One 18-bit pixel, six bits per colour, bit 0 is the LSB
  typedef struct packed {
    logic [5:0] red_level;
    logic [5:0] green_level;
    logic [5:0] blue_level;
  } qrp_pixel_t;

  // Video input pins grouped together
  typedef struct packed {
    logic       pixel_dot_clock;
    logic       line_sync_n;
    logic       frame_sync_n;
    logic       line_window_valid;
    qrp_pixel_t pixel;
  } qrp_video_t;

  // Pixel handed to the panel array with its position
  typedef struct packed {
    logic       valid;
    logic [8:0] col;
    logic [7:0] row;
    qrp_pixel_t pixel;
  } qrp_out_t;
endpackage

/* test/qrp_panel_timing_monitor.sv */
/* Port checker for the panel timing receiver.
   Assumes one clock domain, clk, with synchronous active-high rst. */
`timescale 1ns/1ps
`default_nettype none
module qrp_panel_timing_monitor (
  input wire logic                clk,                 // System clock
  input wire logic                rst,                 // Reset, high
  input wire qrp_pkg::qrp_video_t video_in,            // Video pins
  input wire logic                scan_reverse_select, // Mirror select
  input wire logic                dimming_in,          // Dimming pin
  input wire logic                backlight_on,        // Backlight drive
  input wire qrp_pkg::qrp_out_t   pixel_out,           // Addressed pixel
  input wire logic                frame_start          // Visible frame pulse
);
  import qrp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // A pixel that is not the last of its line, then seven quiet cycles
  sequence s_dot_gap;
    pixel_out.valid && (scan_reverse_select ? pixel_out.col != 9'd0 : pixel_out.col != 9'd319)
      ##1 !pixel_out.valid [*7];
  endsequence
  a_backlight_follow: assert property (!$past(rst) && !$past(rst, 2) && !$past(rst, 3)
    |-> backlight_on == $past(dimming_in, 3)) else $error("backlight does not follow dimming");
  a_valid_single: assert property (pixel_out.valid |=> !pixel_out.valid)
    else $error("pixel valid longer than one cycle");
  a_addr_range: assert property (pixel_out.valid |-> pixel_out.col <= 9'd319 && pixel_out.row <= 8'd239)
    else $error("pixel address outside the visible area");
  a_start_single: assert property ($rose(frame_start) |=> $fell(frame_start))
    else $error("frame start longer than one cycle");
  a_pixel_data: assert property (pixel_out.valid |-> pixel_out.pixel == $past(video_in.pixel, 3))
    else $error("pixel data differs from the pins");
  a_col_step: assert property (s_dot_gap |=> pixel_out.valid && pixel_out.col ==
    (scan_reverse_select ? $past(pixel_out.col, 8) - 9'd1 : $past(pixel_out.col, 8) + 9'd1))
    else $error("column does not step by one per dot");
  a_first_pixel: assert property (frame_start |-> ##[8:1000] (pixel_out.valid &&
    pixel_out.row == (scan_reverse_select ? 8'd239 : 8'd0) &&
    pixel_out.col == (scan_reverse_select ? 9'd319 : 9'd0))) else $error("first pixel misplaced");
  a_vsync_quiet: assert property (!video_in.frame_sync_n |-> !pixel_out.valid)
    else $error("pixel given during frame sync");
endmodule
bind qrp_panel_timing qrp_panel_timing_monitor u_mon (.clk(clk), .rst(rst), .video_in(video_in),
  .scan_reverse_select(scan_reverse_select), .dimming_in(dimming_in), .backlight_on(backlight_on),
  .pixel_out(pixel_out), .frame_start(frame_start));
`default_nettype wire

/* test/qrp_panel_timing_tb_top.sv */
/* Self-checking bench for the panel timing receiver.
   Assumes the video source model and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none
module qrp_panel_timing_tb_top;
  import qrp_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, scan_reverse_select = 1'b0, dimming_in = 1'b0;
  logic       run = 1'b0, use_window = 1'b0, started = 1'b0, collect = 1'b0;
  logic       backlight_on, frame_start;
  qrp_video_t video_in;
  qrp_out_t   pixel_out;
  logic [8:0] x;
  logic [7:0] y;
  int         mismatches = 0, samples_checked = 0, got = 0, cycles = 0;
  always #50 clk = ~clk;
  qrp_panel_timing dut (.clk(clk), .rst(rst), .video_in(video_in), .scan_reverse_select(scan_reverse_select),
    .dimming_in(dimming_in), .backlight_on(backlight_on), .pixel_out(pixel_out), .frame_start(frame_start));
  qrp_video_source src (.run(run), .use_window(use_window), .vid(video_in));
  // Compare and count
  task automatic check(input logic [18:0] g, input logic [18:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Verdict and end of run
  task automatic complete_run;
    $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      complete_run();
    end
  end
  // Scoreboard of visible pixels, none before the frame start
  always @(negedge clk) begin
    if (frame_start) started = 1'b1;
    if (pixel_out.valid && collect) begin
      x = scan_reverse_select ? 9'd319 - pixel_out.col : pixel_out.col;
      y = scan_reverse_select ? 8'd239 - pixel_out.row : pixel_out.row;
      got++;
      check({started, pixel_out.pixel}, {1'b1, x, 9'(y) + 9'd8});
    end
  end
  // Backlight follows the dimming pin after three cycles
  task automatic backlight_case;
    @(negedge clk) dimming_in = 1'b1;
    @(negedge clk) check(19'(backlight_on), 19'd0);
    repeat (3) @(negedge clk);
    check(19'(backlight_on), 19'd1);
    dimming_in = 1'b0;
    repeat (4) @(negedge clk);
    check(19'(backlight_on), 19'd0);
  endtask
  // From reset to the frame start, then the first two full visible lines
  task automatic run_frame(input logic mir, input logic win);
    int i;
    @(negedge clk);
    rst = 1'b1;
    scan_reverse_select = mir;
    use_window = win;
    started = 1'b0;
    got = 0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    collect = 1'b1;
    run = 1'b1;
    for (i = 0; i < 24000 && !started; i++) @(negedge clk);
    check(19'(i / 3200), 19'd7);
    repeat (6500) @(negedge clk);
    collect = 1'b0;
    run = 1'b0;
    check(19'(got), 19'd640);
    repeat (3300) @(negedge clk);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    backlight_case();
    run_frame(1'b0, 1'b1);
    run_frame(1'b1, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire

/* test/qrp_video_source.sv */
/* Model of the display timing controller driving the video pins.
   Assumes nothing of the system clock; its dot clock stops between runs. */
`timescale 1ns/1ps
`default_nettype none
module qrp_video_source (
  input wire logic                run,        // Frames flow while high
  input wire logic                use_window, // Drive the window enable
  output var qrp_pkg::qrp_video_t vid         // Video pins to the panel
);
  import qrp_pkg::*;
  int x;
  // pins always driven, syncs idle high
  initial vid = 22'h180000;
  // frame and line loops span the whole line and frame
  // rate, supply and dimming pace are not modelled here
  // Frame generator, lines end before stopping
  always begin
    wait (run);
    #13;
    for (int ln = 1; run; ln = ln % 262 + 1) begin
      for (int d = 1; d <= 400; d++) begin
        // Fixed start: pixel 0 rides the dot after the 52nd count
        x = d - (use_window ? 21 : 53);
        vid.line_sync_n = d > 10;
        vid.frame_sync_n = ln > 2;
        vid.line_window_valid = use_window && d >= 20 && d <= 340;
        // column and line as pixel data
        vid.pixel = {x[8:0], 9'(ln)};
        #400 vid.pixel_dot_clock = 1'b1;
        #400 vid.pixel_dot_clock = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire
